// ==== logic/reset_source_controller.v ====
// Purpose: collect reset requests, hold system reset, record the cause
// Assumes: core, flash, rtc and low-power strobes are on i_ref_clk
// Notes:   pin, comparator, supply, lost-clock and rtc-slow inputs are
//          analog or pin levels and pass a two-flop synchroniser
`include "reset_source_controller_defines.vh"

// Overview of operation
// - watchdog enabled, clocked system_clock/12 after reset
// - watchdog overflow resets, sets dog cause flag
// - watchdog suppressed in suspend/sleep, enable restored
// - internal resets never drive the reset pin
// - enabled data-space write above lock byte resets
// - code-space read above lock byte resets
// - fetch above lock byte resets
// - flash security violation resets
// - flash write/erase without supply monitor resets
// - flash error reset sets bit 6 flag
// - slow rtc oscillator raises oscillator-fail event
// - rtc timer equal alarm raises alarm event
// - bit 7 enables rtc source, reads rtc cause
// - rtc source works in suspend and sleep
// - writing bit 4 forces reset, reads 1
// - bit 5 enables comparator, reads comparator cause
// - bit 2 enables lost clock, reads its cause
// - bit 1 enables supply monitor, reads power cause
// - bit 0 reads 1 after pin reset
// - read-modify-write copies cause flags into the enables
module reset_source_controller #(
   parameter HOLD_CYCLES = `RSC_HOLD_CYCLES,
   parameter ADDR_W      = 16,
   parameter RTC_W       = 32
)(
   // clock and power-on reset
   input  wire              i_ref_clk,
   input  wire              i_rstn,
   // special-function-register access
   input  wire [7:0]        i_sfr_addr,
   input  wire              i_sfr_wr,
   input  wire              i_sfr_rd,
   input  wire [7:0]        i_sfr_wdata,
   output reg  [7:0]        o_sfr_rdata,
   // watchdog in the counter array
   input  wire              i_dog_ctl_wr,
   input  wire              i_dog_ctl_en,
   input  wire              i_dog_overflow,
   output reg               o_dog_enable,
   output reg               o_dog_tick,
   // flash access checks
   input  wire [ADDR_W-1:0] i_lock_byte_addr,
   input  wire              i_flash_write_enable,
   input  wire              i_dsm_write,
   input  wire [ADDR_W-1:0] i_dsm_addr,
   input  wire              i_csr_read,
   input  wire [ADDR_W-1:0] i_csr_addr,
   input  wire              i_fetch,
   input  wire [ADDR_W-1:0] i_fetch_addr,
   input  wire              i_flash_sec_block,
   input  wire              i_flash_wr_erase,
   input  wire              i_vdm_on,
   // real-time clock
   input  wire              i_rtc_ofail_en,
   input  wire              i_rtc_slow,
   input  wire              i_rtc_alarm_en,
   input  wire [RTC_W-1:0]  i_rtc_timer,
   input  wire [RTC_W-1:0]  i_alarm_cmp,
   // analog and pin sources
   input  wire              i_rst_pin_n,
   input  wire              i_cmp_out,
   input  wire              i_cmp_wake_en,
   input  wire              i_vdd_low,
   input  wire              i_lost_clk_timeout,
   // low-power state
   input  wire              i_suspend,
   input  wire              i_sleep,
   // reset outputs
   output reg               o_sys_rst_n,
   output reg               o_rst_pin_oe,
   output reg               o_rtc_event
);

   localparam ST_RUN  = 2'b01;
   localparam ST_HOLD = 2'b10;
   localparam NSYNC   = 5;
   // integer forms first, then cut to the counter widths on purpose
   localparam integer DOG_LAST_I  = `RSC_DOG_DIV - 1;
   localparam integer HOLD_LAST_I = HOLD_CYCLES - 1;
   localparam [`RSC_DOG_DIV_W-1:0] DOG_LAST = DOG_LAST_I[`RSC_DOG_DIV_W-1:0];
   // hold counter is five bits: hold lengths above 32 need a wider counter
   localparam [4:0] HOLD_LAST = HOLD_LAST_I[4:0];

   // two-flop synchronisers for pin and analog levels
   wire [NSYNC-1:0] async_in;
   reg  [NSYNC-1:0] sync1_r;
   reg  [NSYNC-1:0] sync2_r;
   // comparator stored inverted so the flop reset level is its idle level
   assign async_in = {i_lost_clk_timeout, i_vdd_low, ~i_cmp_out, i_rtc_slow, ~i_rst_pin_n};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1)
      begin : g_sync
         always @(posedge i_ref_clk or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               sync1_r[g] <= 1'b0;
               sync2_r[g] <= 1'b0;
            end
            else
            begin
               sync1_r[g] <= async_in[g];
               sync2_r[g] <= sync2_nxt(sync1_r[g]);
            end
         end
      end
   endgenerate

   // second stage reads only the first stage
   function sync2_nxt;
      input d;
      begin
         sync2_nxt = d;
      end
   endfunction

   wire pin_req    = sync2_r[0];
   wire rtc_slow_s = sync2_r[1];
   wire cmp_low_s  = sync2_r[2];
   wire vdd_low_s  = sync2_r[3];
   wire lost_s     = sync2_r[4];

   reg  [1:0]                state_r;
   reg  [4:0]                hold_r;
   reg  [7:0]                flag_r;
   reg                       en_power_r;
   reg                       en_lost_r;
   reg                       en_cmp_r;
   reg                       en_rtc_r;
   reg  [`RSC_DOG_DIV_W-1:0] dog_div_r;

   wire low_power = i_suspend | i_sleep;
   wire reg_wr    = i_sfr_wr & (i_sfr_addr == `RSC_REG_ADDR);
   wire reg_rd    = i_sfr_rd & (i_sfr_addr == `RSC_REG_ADDR);

   // event detection
   wire rtc_event  = (i_rtc_ofail_en & rtc_slow_s) |
                     (i_rtc_alarm_en & (i_rtc_timer == i_alarm_cmp));
   wire flash_err  = (i_flash_write_enable & i_dsm_write & (i_dsm_addr > i_lock_byte_addr)) |
                     (i_csr_read & (i_csr_addr > i_lock_byte_addr)) |
                     (i_fetch & (i_fetch_addr > i_lock_byte_addr)) |
                     i_flash_sec_block |
                     (i_flash_wr_erase & ~i_vdm_on);
   // lost clock and watchdog gated, not cleared, so enables return on wake
   wire dog_req    = i_dog_overflow & o_dog_enable & ~low_power;
   wire lost_req   = lost_s & en_lost_r & ~low_power;
   // comparator keeps working asleep only as a wake source
   wire cmp_req    = cmp_low_s & en_cmp_r & (~low_power | i_cmp_wake_en);
   // rtc source stays live in suspend and sleep
   wire rtc_req    = rtc_event & en_rtc_r;
   wire power_req  = vdd_low_s & en_power_r;
   wire soft_req   = reg_wr & i_sfr_wdata[`RSC_BIT_SOFT];

   // one cause per reset, pin first
   reg [7:0] cause_nxt;
   always @*
   begin
      cause_nxt = 8'h00;
      if (pin_req)
         cause_nxt[`RSC_BIT_PIN] = 1'b1;
      else if (power_req)
         cause_nxt[`RSC_BIT_POWER] = 1'b1;
      else if (lost_req)
         cause_nxt[`RSC_BIT_LOSTCLK] = 1'b1;
      else if (cmp_req)
         cause_nxt[`RSC_BIT_CMP] = 1'b1;
      else if (rtc_req)
         cause_nxt[`RSC_BIT_RTC] = 1'b1;
      else if (flash_err)
         cause_nxt[`RSC_BIT_FLASH] = 1'b1;
      else if (dog_req)
         cause_nxt[`RSC_BIT_DOG] = 1'b1;
      else if (soft_req)
         cause_nxt[`RSC_BIT_SOFT] = 1'b1;
   end

   // any enabled source, pin included, starts a new hold
   wire any_req = |cause_nxt;

   // reset sequencing and cause capture
   always @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_r      <= ST_HOLD;
         hold_r       <= 5'h00;
         // power-on: only the power flag reads 1
         flag_r       <= 8'h02;
         o_sys_rst_n  <= 1'b0;
         en_power_r   <= `RSC_EN_POWER_RST;
         en_lost_r    <= `RSC_EN_LOST_RST;
         en_cmp_r     <= `RSC_EN_CMP_RST;
         en_rtc_r     <= `RSC_EN_RTC_RST;
         o_dog_enable <= `RSC_DOG_EN_RST;
      end
      else
      begin
         case (state_r)
            ST_RUN:
            begin
               if (any_req)
               begin
                  // flags hold only the new cause
                  flag_r      <= cause_nxt;
                  state_r     <= ST_HOLD;
                  hold_r      <= 5'h00;
                  o_sys_rst_n <= 1'b0;
               end
               else if (reg_wr)
               begin
                  // write touches enables only, read-only flags keep value
                  en_rtc_r   <= i_sfr_wdata[`RSC_BIT_RTC];
                  en_cmp_r   <= i_sfr_wdata[`RSC_BIT_CMP];
                  en_lost_r  <= i_sfr_wdata[`RSC_BIT_LOSTCLK];
                  en_power_r <= i_sfr_wdata[`RSC_BIT_POWER];
               end
               // dog enable has its own control write in the counter array
               if (!any_req && i_dog_ctl_wr)
                  o_dog_enable <= i_dog_ctl_en;
            end
            ST_HOLD:
            begin
               // every reset returns the enables to their defaults
               o_dog_enable <= `RSC_DOG_EN_RST;
               en_power_r   <= `RSC_EN_POWER_RST;
               en_lost_r    <= `RSC_EN_LOST_RST;
               en_cmp_r     <= `RSC_EN_CMP_RST;
               en_rtc_r     <= `RSC_EN_RTC_RST;
               // pin held low stretches the reset
               if (pin_req)
                  hold_r <= 5'h00;
               else if (hold_r == HOLD_LAST)
               begin
                  state_r     <= ST_RUN;
                  o_sys_rst_n <= 1'b1;
               end
               else
                  hold_r <= hold_r + 5'h01;
            end
            default:
            begin
               state_r     <= ST_HOLD;
               hold_r      <= 5'h00;
               o_sys_rst_n <= 1'b0;
            end
         endcase
      end
   end

   // watchdog prescaler, restarts with every reset
   always @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         dog_div_r  <= {`RSC_DOG_DIV_W{1'b0}};
         o_dog_tick <= 1'b0;
      end
      else if (state_r != ST_RUN)
      begin
         dog_div_r  <= {`RSC_DOG_DIV_W{1'b0}};
         o_dog_tick <= 1'b0;
      end
      else
      begin
         o_dog_tick <= (dog_div_r == DOG_LAST);
         if (dog_div_r == DOG_LAST)
            dog_div_r <= {`RSC_DOG_DIV_W{1'b0}};
         else
            dog_div_r <= dog_div_r + {{(`RSC_DOG_DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // read port, pin enable and rtc event output
   always @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_sfr_rdata  <= 8'h00;
         o_rst_pin_oe <= 1'b0;
         o_rtc_event  <= 1'b0;
      end
      else
      begin
         // read gives cause flags; enables are write-only
         o_sfr_rdata  <= reg_rd ? flag_r : 8'h00;
         // pin is input only; internal resets leave its level alone
         o_rst_pin_oe <= 1'b0;
         o_rtc_event  <= rtc_event;
      end
   end

endmodule

// ==== logic/reset_source_controller_defines.vh ====
// Purpose: constants for the reset source controller
// Assumes: byte-wide special-function-register access from the core
// Notes:   bit positions index the reset cause and enable register
`ifndef RESET_SOURCE_CONTROLLER_DEFINES_VH
`define RESET_SOURCE_CONTROLLER_DEFINES_VH

// register address in the special-function-register space
`define RSC_REG_ADDR      8'hef

// bit positions of reset_cause_and_enable
`define RSC_BIT_PIN       0
`define RSC_BIT_POWER     1
`define RSC_BIT_LOSTCLK   2
`define RSC_BIT_DOG       3
`define RSC_BIT_SOFT      4
`define RSC_BIT_CMP       5
`define RSC_BIT_FLASH     6
`define RSC_BIT_RTC       7

// enables after a reset: supply monitor, lost clock and watchdog on, comparator and rtc off
`define RSC_EN_POWER_RST  1'b1
`define RSC_EN_LOST_RST   1'b1
`define RSC_EN_CMP_RST    1'b0
`define RSC_EN_RTC_RST    1'b0
`define RSC_DOG_EN_RST    1'b1

// watchdog prescale: system clock divided by 12
`define RSC_DOG_DIV       12
`define RSC_DOG_DIV_W     4

// system reset hold time in clock cycles
`define RSC_HOLD_CYCLES   16

`endif

// ==== dv/reset_source_controller_asserts.sv ====
// Purpose: port checks for the reset source controller
// Assumes: one clock, async active-low reset
// Notes:   hold length checked to eight cycles only
module reset_source_controller_asserts #(
   parameter ADDR_W = 16,
   parameter RTC_W  = 32
)(
   input logic              i_ref_clk, i_rstn, i_sfr_wr, i_dog_overflow, i_suspend, i_sleep,
   input logic              i_rtc_alarm_en, o_rtc_event,
   input logic [RTC_W-1:0]  i_rtc_timer, i_alarm_cmp,
   input logic              i_fetch, i_csr_read, o_dog_enable, o_dog_tick, o_sys_rst_n, o_rst_pin_oe,
   input logic [7:0]        i_sfr_addr, i_sfr_wdata,
   input logic [ADDR_W-1:0] i_fetch_addr, i_csr_addr, i_lock_byte_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   pin_never_driven_a:
      assert property (!o_rst_pin_oe) else $error("reset pin driven");
   soft_force_a:
      assert property (o_sys_rst_n && i_sfr_wr && i_sfr_addr == 8'hef && i_sfr_wdata[4] |=> !o_sys_rst_n)
      else $error("soft reset missing");
   dog_overflow_a:
      assert property (o_sys_rst_n && i_dog_overflow && o_dog_enable && !i_suspend && !i_sleep |=> !o_sys_rst_n)
      else $error("watchdog reset missing");
   dog_on_exit_a:
      assert property ($rose(o_sys_rst_n) |-> o_dog_enable) else $error("watchdog off after reset");
   tick_gap_a:
      assert property (o_dog_tick |=> !o_dog_tick [*8]) else $error("prescale tick too early");
   fetch_rst_a:
      assert property (o_sys_rst_n && i_fetch && i_fetch_addr > i_lock_byte_addr |=> !o_sys_rst_n)
      else $error("illegal fetch not reset");
   code_read_a:
      assert property (o_sys_rst_n && i_csr_read && i_csr_addr > i_lock_byte_addr |=> !o_sys_rst_n)
      else $error("illegal code read not reset");
   hold_min_a:
      assert property ($fell(o_sys_rst_n) |-> !o_sys_rst_n [*8]) else $error("reset pulse too short");
   tick_period_a:
      assert property (o_dog_tick ##12 o_sys_rst_n |-> o_dog_tick) else $error("prescale tick period wrong");
   rtc_alarm_a:
      assert property (i_rtc_alarm_en && i_rtc_timer == i_alarm_cmp |=> o_rtc_event)
      else $error("alarm event missing");
   cover property ($fell(o_sys_rst_n));
   cover property (i_suspend && i_dog_overflow);
   cover property (i_sleep && $fell(o_sys_rst_n));
endmodule

bind reset_source_controller reset_source_controller_asserts #(.ADDR_W(ADDR_W), .RTC_W(RTC_W)) u_chk (.*);

// ==== dv/rst_pin_model.sv ====
// Purpose: board side of the external reset pin
// Assumes: pull-up on the board, pulled low only on request
// Notes:   released pin reads high through the pull-up
module rst_pin_model (
   input  wire logic i_pull_low,
   input  wire logic i_dev_oe,
   output wire logic o_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // open drain: either party can only pull the line low
   assign o_pin_n = (i_pull_low || i_dev_oe) ? 1'b0 : 1'b1;
endmodule

// ==== dv/reset_source_controller_tb_top.sv ====
// Purpose: self-checking bench for the reset source controller
// Assumes: pin model supplies the reset pin level
// Notes:   flash addresses and rtc values random, seed fixed
module reset_source_controller_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_ref_clk = 0, i_rstn = 0, i_sfr_wr = 0, i_sfr_rd = 0, i_dog_ctl_wr = 0, i_dog_ctl_en = 0;
   logic        i_dog_overflow = 0, i_flash_write_enable = 0, i_dsm_write = 0, i_csr_read = 0, i_fetch = 0;
   logic        i_flash_sec_block = 0, i_flash_wr_erase = 0, i_vdm_on = 1, i_rtc_alarm_en = 0, i_cmp_out = 1;
   logic        i_vdd_low = 0, i_lost_clk_timeout = 0, i_suspend = 0, i_sleep = 0, pull_low = 0;
   logic        i_rtc_ofail_en = 0, i_rtc_slow = 0, i_cmp_wake_en = 0;
   logic [7:0]  i_sfr_addr = 8'hef, i_sfr_wdata = 8'h00;
   logic [15:0] i_dsm_addr = 16'h0000, i_csr_addr = 16'h0000, i_fetch_addr = 16'h0000;
   logic [31:0] i_rtc_timer = 32'h0, i_alarm_cmp = 32'h1;
   wire  [7:0]  o_sfr_rdata;
   wire         o_dog_enable, o_dog_tick, o_sys_rst_n, o_rst_pin_oe, o_rtc_event, pin_n;
   integer      n_errors = 0, cmp_count = 0, seed = 40, k, i;
   localparam logic [15:0] LOCK = 16'h3bff;

   reset_source_controller DUT (.*, .i_lock_byte_addr(LOCK), .i_rst_pin_n(pin_n));
   rst_pin_model PIN (.i_pull_low(pull_low), .i_dev_oe(o_rst_pin_oe), .o_pin_n(pin_n));

   always #2 i_ref_clk = ~i_ref_clk;

   task chk(input logic [7:0] s, input logic [7:0] e, input string nm);
      cmp_count++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task test_done;
      if (n_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   task wr(input logic [7:0] d);
      i_sfr_wr = 1;
      i_sfr_wdata = d;
      cyc(1);
      i_sfr_wr = 0;
      cyc(1);
   endtask
   // cause flag expected for each source code of src
   function automatic logic [7:0] exp_flag(input integer c);
      exp_flag = 8'h01 << (c == 12 ? 7 : (c > 7 ? 6 : c));
   endfunction
   // read data stands one cycle only, so sample right after the taking edge
   task rd(input logic [7:0] e);
      logic [7:0] s;
      i_sfr_rd = 1;
      cyc(1);
      i_sfr_rd = 0;
      s = o_sfr_rdata;
      if (e[1]) s = s & 8'h02;
      chk(s, e, "flags");
   endtask
   task run;
      cyc(4);
      for (i = 0; i < 300 && o_sys_rst_n !== 1'b1; i++) cyc(1);
      if (i == 300)
      begin
         chk(8'h00, 8'h01, "reset_exit");
         test_done;
      end
      cyc(2);
   endtask
   task calm;
      repeat (6)
      begin
         cyc(1);
         chk(8'(o_sys_rst_n), 8'h01, "quiet");
      end
   endtask
   // one source per code; async ones held long enough to pass the synchroniser
   task src(input integer c, input logic v);
      case (c)
         0: pull_low = v;
         1: i_vdd_low = v;
         2: i_lost_clk_timeout = v;
         3: i_dog_overflow = v;
         4: if (v) wr(8'hb6);
         5: i_cmp_out = !v;
         6: {i_flash_write_enable, i_dsm_write} = {v, v};
         7: {i_rtc_alarm_en, i_alarm_cmp} = {v, i_rtc_timer};
         8: i_csr_read = v;
         9: i_fetch = v;
         10: i_flash_sec_block = v;
         11: {i_vdm_on, i_flash_wr_erase} = {!v, v};
         default: {i_rtc_ofail_en, i_rtc_slow} = {v, v};
      endcase
   endtask
   task hit(input integer c, input integer n);
      src(c, 1'b1);
      cyc(n);
      src(c, 1'b0);
   endtask

   initial
   begin
      cyc(4);
      i_rstn = 1;
      run;
      rd(8'h02);
      {i_dog_ctl_wr, i_dog_ctl_en} = 2'b10;
      cyc(1);
      i_dog_ctl_wr = 0;
      for (k = 0; k < 13; k++)
      begin
         i_rtc_timer = $random(seed);
         {i_dsm_addr, i_csr_addr, i_fetch_addr} = {3{LOCK + 16'h0001 + (16'($random(seed)) & 16'h03ff)}};
         wr(8'ha6);
         hit(k, 4);
         run;
         rd(exp_flag(k));
         chk(8'(o_dog_enable), 8'h01, "dog_enable");
      end
      wr(8'h02);
      {i_dsm_addr, i_fetch_addr} = {LOCK, LOCK};
      i_csr_addr = LOCK - (16'($random(seed)) & 16'h0fff);
      for (k = 2; k < 10; k++)
         if (k != 3 && k != 4 && k != 7)
         begin
            hit(k, 4);
            calm;
         end
      i_suspend = 1;
      hit(3, 1);
      calm;
      i_suspend = 0;
      hit(3, 1);
      run;
      rd(8'h08);
      wr(8'h82);
      i_sleep = 1;
      hit(7, 1);
      run;
      i_sleep = 0;
      rd(8'h80);
      wr(8'h22);
      i_sleep = 1;
      hit(5, 4);
      calm;
      i_cmp_wake_en = 1;
      hit(5, 4);
      run;
      {i_sleep, i_cmp_wake_en} = 2'b00;
      rd(8'h20);
      test_done;
   end
endmodule
